// ==== sim/host_model.sv ====
// Purpose: Host controller model driving the serial command link
// Assumes: Mode 0 clocking with a 125 ns serial clock, MSB first
// Notes: Data line idles at the inverse of its last bit, clock low between frames
`timescale 1ns/1ns
`default_nettype none
module host_model (
    output var logic convert_select,
    output var logic sclk,
    output var logic sdi,
    input wire logic [1:0] lanes
);
    initial begin
        convert_select = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // Long frames lead with filler, since only the last 32 bits count
    task automatic frame(input logic [31:0] cmd, input int n, output logic [31:0] got,
        output logic [15:0] lo);
        int i;
        int j;
        got = 32'h0;
        lo = 16'h0;
        convert_select = 1'b0;
        #97;
        for (i = 0; i < n; i++) begin
            j = (n < 32) ? i : i - n + 32;
            sdi = (j < 0) ? ~sdi : cmd[31 - j];
            #62;
            sclk = 1'b1;
            if (i < 32) got[31 - i] = lanes[0];
            if (i < 16) lo[15 - i] = lanes[1];
            #63;
            sclk = 1'b0;
        end
        #40;
        convert_select = 1'b1;
        sdi = ~sdi;
        #250;
    endtask : frame
endmodule : host_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the serial command decoder
// Assumes: Host model on the serial link, Wishbone master in this module
// Notes: Random commands from a fixed seed, predicted by a byte register model
`include "scd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, done = 1'b0, cyc = 1'b0, we = 1'b0, have_rd = 1'b0;
    logic [17:0] res = 18'h0;
    logic [3:0] pid = 4'h0, rng = 4'h0;
    logic [1:0] sal = 2'h0, ial = 2'h0, lanes;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0, rdat, q, got, e, cmd, rdw;
    logic sel_n, sck, sdi, ack, oen, rdy, src_w;
    logic [1:0] kind;
    logic [15:0] lo;
    logic [31:0] src_got = 32'h0;
    logic [7:0] regs [16];
    logic [4:0] ops [7] = '{`OP_CLEAR, `OP_SET, `OP_WRITE, `OP_READ_HW, `OP_READ_BYTE,
        5'h00, 5'h1F};
    int num_errors = 0, comparisons = 0, seed = 14412, k, n, src_n = 0;

    always #5 clk = ~clk;

    // In internal clock mode each output bit stands from a falling to the next falling edge
    always @(posedge src_w) begin
        if (src_n < 32) src_got[31 - src_n] = lanes[0];
        src_n++;
    end

    host_model host (.convert_select(sel_n), .sclk(sck), .sdi(sdi), .lanes(lanes));
    serial_command_decoder #(.REG_BYTES(16)) dut (.CLOCK(clk), .RESET_N(rst_n),
        .CONVERT_SELECT(sel_n), .SCLK(sck), .SDI(sdi), .CONV_DONE(done), .CONV_RESULT(res),
        .POSITION_ID(pid), .SUPPLY_ALARM(sal), .INPUT_ALARM(ial), .RANGE_CODE(rng),
        .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SERIAL_OUT_LANES(lanes),
        .SERIAL_OUT_EN(oen), .READY_STROBE(rdy), .SOURCE_CLK(src_w));

    task automatic report_and_stop();
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Ack is read at the rising edge, before that edge's own updates land
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
        if (ack !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
        r = rdat;
        cyc <= 1'b0;
    endtask : wb

    function automatic logic [31:0] outword();
        logic [31:0] w;
        int p;
        w = {res, 14'h0};
        p = 14;
        if (regs[0][2]) return regs[0][1] ? (regs[0][0] ? `PAT_3 : `PAT_2) : {32{regs[0][0]}};
        if (have_rd) return rdw;
        if (regs[0][7]) begin p -= 4; w[p +: 4] = pid; end
        if (regs[0][6]) begin p -= 2; w[p +: 2] = sal; end
        if (regs[0][5]) begin p -= 2; w[p +: 2] = ial; end
        if (regs[0][4]) begin p -= 4; w[p +: 4] = rng; end
        if (regs[0][3]) begin p -= 2; w[p +: 2] = {^res, ^w[13:0]}; end
        return w;
    endfunction : outword

    function automatic void apply(input logic [31:0] c);
        logic [7:0] a, h;
        logic ok;
        a = c[23:16];
        h = {a[7:1], 1'b0};
        ok = (c[24:20] == 5'h00);
        have_rd = 1'b0;
        case (c[31:27])
            `OP_CLEAR: if (ok) {regs[h + 1], regs[h]} = {regs[h + 1], regs[h]} & ~c[15:0];
            `OP_SET: if (ok) {regs[h + 1], regs[h]} = {regs[h + 1], regs[h]} | c[15:0];
            `OP_WRITE: if (ok) begin
                case (c[26:25])
                    `SUB_BOTH: {regs[h + 1], regs[h]} = c[15:0];
                    `SUB_HI: regs[h + 1] = c[15:8];
                    `SUB_LO: regs[h] = c[7:0];
                    default: ;
                endcase
            end
            `OP_READ_HW: begin
                have_rd = 1'b1;
                rdw = ok ? {regs[h + 1], regs[h], 16'h0} : 32'h0;
            end
            `OP_READ_BYTE: begin
                have_rd = 1'b1;
                rdw = ok ? {regs[a[3:0]], 24'h0} : 32'h0;
            end
            default: ;
        endcase
    endfunction : apply

    initial begin
        for (k = 0; k < 16; k++) regs[k] = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wb(1'b0, 8'hFC, 32'h0, q);
        check(q, 32'h0);
        for (k = 0; k < 60; k++) begin
            @(posedge clk);
            res <= 18'($random(seed));
            {pid, sal, ial, rng} <= 12'($random(seed));
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
            @(negedge clk);
            check({31'h0, rdy}, 32'h1);
            e = outword();
            cmd = $random(seed);
            cmd[31:27] = ops[$unsigned($random(seed)) % 7];
            cmd[24:20] = (k % 9 == 4) ? 5'h01 : 5'h00;
            if (k % 10 == 5) cmd = 32'h0;
            n = (k % 6 == 1) ? 20 : ((k % 6 == 3) ? 37 : 32);
            host.frame(cmd, n, got, lo);
            check(got, (n < 32) ? e & ~(32'hFFFFFFFF >> n) : e);
            check({16'h0, lo}, {16'h0, e[15:0]});
            check({30'h0, oen, rdy}, 32'h0);
            wb(1'b0, 8'h0C, 32'h0, q);
            check(q, (n >= 32) ? cmd : 32'h0);
            kind = (n < 32) ? 2'h0 : ((cmd[31:27] == `OP_READ_BYTE) ? 2'h1 :
                ((cmd[31:27] == `OP_READ_HW) ? 2'h2 : 2'h0));
            wb(1'b0, 8'h08, 32'h0, q);
            check(q, {24'h0, kind, (n < 32) ? 6'(n) : `FULL_FRAME});
            if (n >= 32) apply(cmd);
            else have_rd = 1'b0;
        end
        // Internal output clock, divider 3: the word leaves on SOURCE_CLK, not on the host clock
        wb(1'b1, 8'h04, 32'h00000003, q);
        wb(1'b1, 8'h00, 32'h00000001, q);
        wb(1'b0, 8'h04, 32'h0, q);
        check(q, 32'h00000003);
        wb(1'b0, 8'h00, 32'h0, q);
        check(q, 32'h00000001);
        e = outword();
        src_n = 0;
        host.frame(32'h0, 32, got, lo);
        apply(32'h0);
        check(src_got, e);
        check({31'h0, src_n >= 32}, 32'h1);
        check({31'h0, src_w}, 32'h0);
        for (k = 0; k < 16; k++) begin
            wb(1'b0, 8'(8'h40 + 4 * k), 32'h0, q);
            check(q, {24'h0, regs[k]});
        end
        wb(1'b1, 8'h54, 32'h000000A5, q);
        wb(1'b0, 8'h54, 32'h0, q);
        check(q, 32'h000000A5);
        report_and_stop();
    end

    initial begin
        #900000;
        num_errors++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire

// ==== verilog/scd_cfg.svh ====
// Purpose: Constants for the serial command decoder
// Assumes: Included by the decoder module by bare name
// Notes: Offsets, field positions, opcodes and patterns
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
`define OP_CLEAR 5'h18
`define OP_READ_HW 5'h19
`define OP_READ_BYTE 5'h09
`define OP_WRITE 5'h1A
`define OP_SET 5'h1B
`define SUB_BOTH 2'h0
`define SUB_HI 2'h1
`define SUB_LO 2'h2
`define FULL_FRAME 6'h20
`define RESULT_LSB 6'h0E
`define POSID_W 6'h04
`define ALARM_W 6'h02
`define RANGE_W 6'h04
`define PAR_W 6'h02
`define OWC_ADDR 4'h0
`define FPS_TOP 2
`define PAR_BIT 3
`define RNG_BIT 4
`define INA_BIT 5
`define SUPA_BIT 6
`define POSID_BIT 7
`define PAT_0 32'h00000000
`define PAT_1 32'hFFFFFFFF
`define PAT_2 32'h55555555
`define PAT_3 32'hAAAAAAAA
`define WB_CONTROL 6'h00
`define WB_DIVIDER 6'h01
`define WB_STATUS 6'h02
`define WB_LASTCMD 6'h03
`define WB_REGBASE 6'h10
`endif

// ==== verilog/scd_pkg.sv ====
// Purpose: Types for the serial command decoder
// Assumes: Nothing
// Notes: Constants live in scd_cfg.svh
package scd_pkg;
    typedef enum logic [1:0] {RD_NONE, RD_BYTE, RD_HALF} readback_t;
endpackage : scd_pkg

// ==== verilog/serial_command_decoder.sv ====
// Purpose: Serial command decoder and output word builder of a converter
// Assumes: SPI mode 0 on the serial pins, all pins sampled by CLOCK
// Notes: Byte registers also reachable over classic Wishbone
// What this block does
// - Command bits sampled on serial clock edges
// - Half-word commands force address bit zero
// - Zero or unknown opcodes change nothing
// - Bit-clear zeroes bits marked one
// - Bit-set sets bits marked one
// - Half-word read returns sixteen bits next frame
// - Byte read returns eight bits next frame
// - Write sub-field 00 stores both bytes
// - Write sub-field 01 stores upper byte only
// - Write sub-field 10 stores lower byte only
// - Full commands execute at select rising edge
// - Fixed pattern overrides read-back and result
// - Otherwise latest conversion result is sent
// - Enabled flags appended in fixed order
// - Unused output bits are zero
// - Output shifts on serial or internal clock
// - Short frames never write registers
// - Select falling clears command, loads output
// - Flag widths four, two, two, four, two
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`include "scd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module serial_command_decoder #(
    parameter int REG_BYTES = 16
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic CONVERT_SELECT,
    input wire logic SCLK,
    input wire logic SDI,
    input wire logic CONV_DONE,
    input wire logic [17:0] CONV_RESULT,
    input wire logic [3:0] POSITION_ID,
    input wire logic [1:0] SUPPLY_ALARM,
    input wire logic [1:0] INPUT_ALARM,
    input wire logic [3:0] RANGE_CODE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [1:0] SERIAL_OUT_LANES,
    output logic SERIAL_OUT_EN,
    output logic READY_STROBE,
    output logic SOURCE_CLK
);
    import scd_pkg::*;

    localparam int AW = $clog2(REG_BYTES);

    typedef struct packed {
        logic cs1;
        logic cs2;
        logic csd;
        logic sk1;
        logic sk2;
        logic skd;
        logic sd1;
        logic sd2;
        logic [31:0] isr;
        logic [5:0] cnt;
        logic [31:0] cmd;
        logic [31:0] osr;
        readback_t rd;
        logic rd_oob;
        logic [AW-1:0] rd_idx;
        logic [REG_BYTES-1:0][7:0] regs;
        logic int_clk;
        logic [7:0] div;
        logic [7:0] divcnt;
        logic src;
        logic [17:0] result;
        logic ready;
        logic oen;
        logic ack;
        logic [31:0] rdat;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic cs_fall, cs_rise, sk_rise, sk_fall, tick, full, in_map, wb_go, wb_wr;
    logic [31:0] w;
    logic [31:0] word;
    logic [5:0] pos;
    logic [4:0] op;
    logic [1:0] sub;
    logic [8:0] a9;
    logic [15:0] d16;
    logic [15:0] pair;
    logic [AW-1:0] ev;
    logic [AW-1:0] hi;
    logic [AW-1:0] bi;
    logic [5:0] wi;
    logic [7:0] owc;

    always_comb begin
        s_nxt = s_r;
        // Edges are taken only from the second synchroniser stage
        cs_fall = s_r.csd && !s_r.cs2;
        cs_rise = !s_r.csd && s_r.cs2;
        sk_rise = !s_r.skd && s_r.sk2;
        sk_fall = s_r.skd && !s_r.sk2;
        tick = (s_r.divcnt == s_r.div);
        full = (s_r.cnt == `FULL_FRAME);
        op = s_r.isr[31:27];
        sub = s_r.isr[26:25];
        a9 = s_r.isr[24:16];
        d16 = s_r.isr[15:0];
        in_map = ((a9 >> AW) == 9'h000);
        ev = {a9[AW-1:1], 1'b0};
        hi = {a9[AW-1:1], 1'b1};
        pair = {s_r.regs[hi], s_r.regs[ev]};
        wb_go = WB_CYC_I && WB_STB_I && !s_r.ack;
        wb_wr = wb_go && WB_WE_I && WB_SEL_I[0];
        wi = WB_ADR_I[7:2];
        bi = AW'(wi - `WB_REGBASE);
        owc = s_r.regs[`OWC_ADDR];

        // Conversion word: result on top, enabled flags packed below it
        w = {s_r.result, 14'h0000};
        pos = `RESULT_LSB;
        if (owc[`POSID_BIT]) begin
            pos = pos - `POSID_W;
            w = w | (32'(POSITION_ID) << pos);
        end
        if (owc[`SUPA_BIT]) begin
            pos = pos - `ALARM_W;
            w = w | (32'(SUPPLY_ALARM) << pos);
        end
        if (owc[`INA_BIT]) begin
            pos = pos - `ALARM_W;
            w = w | (32'(INPUT_ALARM) << pos);
        end
        if (owc[`RNG_BIT]) begin
            pos = pos - `RANGE_W;
            w = w | (32'(RANGE_CODE) << pos);
        end
        if (owc[`PAR_BIT]) begin
            pos = pos - `PAR_W;
            w = w | (32'({^s_r.result, ^w[13:0]}) << pos);
        end

        // Next frame's word: pattern beats read-back beats result
        if (owc[`FPS_TOP]) begin
            unique case (owc[1:0])
                2'h0: word = `PAT_0;
                2'h1: word = `PAT_1;
                2'h2: word = `PAT_2;
                2'h3: word = `PAT_3;
            endcase
        end else begin
            unique case (s_r.rd)
                RD_NONE: word = w;
                RD_BYTE: word = s_r.rd_oob ? 32'h0 : {s_r.regs[s_r.rd_idx], 24'h0};
                RD_HALF: word = s_r.rd_oob ? 32'h0 :
                    {s_r.regs[s_r.rd_idx | AW'(1)], s_r.regs[s_r.rd_idx], 16'h0};
                default: word = w;
            endcase
        end

        s_nxt.cs1 = CONVERT_SELECT;
        s_nxt.cs2 = s_r.cs1;
        s_nxt.csd = s_r.cs2;
        s_nxt.sk1 = SCLK;
        s_nxt.sk2 = s_r.sk1;
        s_nxt.skd = s_r.sk2;
        s_nxt.sd1 = SDI;
        s_nxt.sd2 = s_r.sd1;

        s_nxt.divcnt = tick ? 8'h00 : s_r.divcnt + 8'h01;
        if (CONV_DONE) begin
            s_nxt.result = CONV_RESULT;
            s_nxt.ready = 1'b1;
        end

        // Wishbone slave, one wait state, serial writes win a collision
        s_nxt.ack = wb_go;
        if (wb_go) begin
            s_nxt.rdat = 32'h0;
            if (wi == `WB_CONTROL) begin
                s_nxt.rdat = 32'(s_r.int_clk);
            end else if (wi == `WB_DIVIDER) begin
                s_nxt.rdat = 32'(s_r.div);
            end else if (wi == `WB_STATUS) begin
                s_nxt.rdat = 32'({s_r.ready, s_r.oen, s_r.rd, s_r.cnt});
            end else if (wi == `WB_LASTCMD) begin
                s_nxt.rdat = s_r.cmd;
            end else if (wi >= `WB_REGBASE && 32'(wi - `WB_REGBASE) < REG_BYTES) begin
                s_nxt.rdat = 32'(s_r.regs[bi]);
            end
        end
        if (wb_wr) begin
            if (wi == `WB_CONTROL) begin
                s_nxt.int_clk = WB_DAT_I[0];
            end else if (wi == `WB_DIVIDER) begin
                s_nxt.div = WB_DAT_I[7:0];
            end else if (wi >= `WB_REGBASE && 32'(wi - `WB_REGBASE) < REG_BYTES) begin
                s_nxt.regs[bi] = WB_DAT_I[7:0];
            end
        end

        if (!s_r.cs2) begin
            if (sk_rise) begin
                s_nxt.isr = {s_r.isr[30:0], s_r.sd2};
                if (!full) begin
                    s_nxt.cnt = s_r.cnt + 6'h01;
                end
            end
            // Internal clock runs only inside the frame
            if (s_r.int_clk && tick) begin
                s_nxt.src = !s_r.src;
            end
            if ((!s_r.int_clk && sk_fall) || (s_r.int_clk && tick && s_r.src)) begin
                s_nxt.osr = {s_r.osr[30:0], 1'b0};
            end
        end else begin
            s_nxt.src = 1'b0;
        end

        if (cs_fall) begin
            s_nxt.cnt = 6'h00;
            s_nxt.cmd = 32'h0;
            s_nxt.osr = word;
            s_nxt.oen = 1'b1;
            s_nxt.ready = 1'b0;
            s_nxt.src = 1'b0;
        end

        if (cs_rise) begin
            s_nxt.oen = 1'b0;
            s_nxt.ready = 1'b0;
            s_nxt.rd = RD_NONE;
            s_nxt.cmd = full ? s_r.isr : 32'h0;
            // A short frame leaves every register alone
            if (full) begin
                s_nxt.rd_oob = !in_map;
                unique case (op)
                    `OP_CLEAR: if (in_map) begin
                        {s_nxt.regs[hi], s_nxt.regs[ev]} = pair & ~d16;
                    end
                    `OP_SET: if (in_map) begin
                        {s_nxt.regs[hi], s_nxt.regs[ev]} = pair | d16;
                    end
                    `OP_READ_HW: begin
                        s_nxt.rd = RD_HALF;
                        s_nxt.rd_idx = ev;
                    end
                    `OP_READ_BYTE: begin
                        s_nxt.rd = RD_BYTE;
                        s_nxt.rd_idx = a9[AW-1:0];
                    end
                    `OP_WRITE: if (in_map) begin
                        unique case (sub)
                            `SUB_BOTH: {s_nxt.regs[hi], s_nxt.regs[ev]} = d16;
                            `SUB_HI: s_nxt.regs[hi] = d16[15:8];
                            `SUB_LO: s_nxt.regs[ev] = d16[7:0];
                            default: ;
                        endcase
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            s_r <= '0;
            // Select idles high; a zero here would fake a frame end after reset
            s_r.cs1 <= 1'b1;
            s_r.cs2 <= 1'b1;
            s_r.csd <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign WB_DAT_O = s_r.rdat;
    assign WB_ACK_O = s_r.ack;
    assign SERIAL_OUT_LANES = {s_r.osr[15], s_r.osr[31]};
    assign SERIAL_OUT_EN = s_r.oen;
    assign READY_STROBE = s_r.ready;
    assign SOURCE_CLK = s_r.src;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    sequence s_full_cmd(logic [4:0] code);
        cs_rise && full && op == code && in_map;
    endsequence

    a_sample_bit: assert property (
        sk_rise && !s_r.cs2 |=> s_r.isr[0] == $past(s_r.sd2))
        else $error("serial bit not captured");
    a_fall_clears: assert property (
        cs_fall |=> s_r.cmd == 32'h0 && s_r.cnt == 6'h00 && s_r.osr == $past(word))
        else $error("frame start did not clear command or load output");
    a_short_frame: assert property (
        cs_rise && !full && !wb_wr |=> s_r.regs == $past(s_r.regs))
        else $error("short frame changed a register");
    a_clear_bits: assert property (
        s_full_cmd(`OP_CLEAR) |=> ({s_r.regs[$past(hi)], s_r.regs[$past(ev)]} & $past(d16)) == 16'h0)
        else $error("bit clear left a bit set");
    a_set_bits: assert property (
        s_full_cmd(`OP_SET) |=> ({s_r.regs[$past(hi)], s_r.regs[$past(ev)]} & $past(d16)) == $past(d16))
        else $error("bit set left a bit clear");
    a_half_read: assert property (
        s_full_cmd(`OP_READ_HW) ##1 (!cs_fall)[*1] |-> s_r.rd == RD_HALF && !s_r.rd_idx[0])
        else $error("half-word read not armed on even address");
    a_byte_zeros: assert property (
        cs_fall && s_r.rd == RD_BYTE && !owc[`FPS_TOP] |=> s_r.osr[23:0] == 24'h0)
        else $error("byte read word not zero filled");
    a_shift_sclk: assert property (
        !s_r.int_clk && sk_fall && !s_r.cs2 && !cs_fall |=> s_r.osr == {$past(s_r.osr[30:0]), 1'b0})
        else $error("output did not shift on serial clock");
    a_drive_frame: assert property (
        $rose(SERIAL_OUT_EN) |-> $past(cs_fall))
        else $error("output enabled outside frame start");
    a_write_both: assert property (
        s_full_cmd(`OP_WRITE) ##0 (sub == `SUB_BOTH) |=>
            {s_r.regs[$past(hi)], s_r.regs[$past(ev)]} == $past(d16))
        else $error("half-word write not stored");
    a_write_upper: assert property (
        s_full_cmd(`OP_WRITE) ##0 (sub == `SUB_HI && !wb_wr) |=>
            s_r.regs[$past(hi)] == $past(d16[15:8]) && s_r.regs[$past(ev)] == $past(pair[7:0]))
        else $error("upper-byte write touched the wrong byte");
    a_write_lower: assert property (
        s_full_cmd(`OP_WRITE) ##0 (sub == `SUB_LO && !wb_wr) |=>
            s_r.regs[$past(ev)] == $past(d16[7:0]) && s_r.regs[$past(hi)] == $past(pair[15:8]))
        else $error("lower-byte write touched the wrong byte");
    a_noop_cmd: assert property (
        cs_rise && full && !wb_wr && op != `OP_CLEAR && op != `OP_SET &&
            (op != `OP_WRITE || sub == 2'h3) |=> s_r.regs == $past(s_r.regs))
        else $error("no-operation command changed a register");
    a_pattern_wins: assert property (
        cs_fall && owc[`FPS_TOP] |=> s_r.osr == ($past(owc[1]) ?
            ($past(owc[0]) ? `PAT_3 : `PAT_2) : {32{$past(owc[0])}}))
        else $error("fixed pattern not loaded");
    a_result_top: assert property (
        cs_fall && !owc[`FPS_TOP] && s_r.rd == RD_NONE |=> s_r.osr[31:14] == $past(s_r.result))
        else $error("conversion result not on top of output word");
    a_short_noread: assert property (
        cs_rise && !full |=> s_r.rd == RD_NONE && s_r.cmd == 32'h0)
        else $error("short frame armed a read or kept a command");
endmodule : serial_command_decoder
`default_nettype wire
